/* File: design/scgb_regs.svh */
`ifndef SCGB_REGS_SVH
`define SCGB_REGS_SVH

`define SCGB_ADDR_W 12
`define SCGB_RUN_OFS 12'h100
`define SCGB_SLEEP_OFS 12'h110
`define SCGB_DEEP_OFS 12'h120
`define SCGB_CFG_OFS 12'h130
`define SCGB_IST_OFS 12'h140
`define SCGB_IMSK_OFS 12'h144
`define SCGB_STATE_OFS 12'h148

`define SCGB_HIB_BIT 6
`define SCGB_WDT_BIT 3
`define SCGB_ACG_BIT 0
`define SCGB_MODE_LSB 8

`define SCGB_IRQ_HIB_BIT 0
`define SCGB_IRQ_WDT_BIT 1
`define SCGB_IRQ_W 2

`define SCGB_GATE_RST 32'h0000_0040
`define SCGB_GATE_WMASK 32'h0000_0048
`define SCGB_CFG_RST 32'h0000_0000
`define SCGB_CFG_WMASK 32'h0000_0001
`define SCGB_IRQ_RST 2'h0

`endif

/* File: design/scgb_pkg.sv */
package scgb_pkg;

	typedef enum logic [1:0] {SCGB_MODE_RUN, SCGB_MODE_SLEEP, SCGB_MODE_DEEP} scgb_mode_t;

	typedef enum logic {SCGB_APB_IDLE, SCGB_APB_ACK} scgb_apb_st_t;

endpackage : scgb_pkg

/* File: design/scgb_gate_reg.sv */
`timescale 1ns/1ps
`include "scgb_regs.svh"

// one software word with a fixed set of writable bits
module scgb_gate_reg
#(
	parameter logic [31:0] RST_VAL = `SCGB_GATE_RST,
	parameter logic [31:0] WR_MASK = `SCGB_GATE_WMASK
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [31:0] wdata,
	output logic [31:0] value_q
);

	logic [31:0] value_d;

	// read-only bits never leave their reset value
	assign value_d = wr_en ? ((wdata & WR_MASK) | (RST_VAL & ~WR_MASK)) : value_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			value_q <= RST_VAL; // R03
		else
			value_q <= value_d;
	end

endmodule : scgb_gate_reg

/* File: design/scgb_unit_gate.sv */
`timescale 1ns/1ps

// clock enable and access check for one gated unit
module scgb_unit_gate
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic gate_en,
	input wire logic access,
	output logic clk_en_q,
	output logic fault_q
);

	logic fault_d;

	// access checked against the enable the unit is really running with
	assign fault_d = access & ~clk_en_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_en_q <= 1'b0;
			fault_q <= 1'b0;
		end
		else
		begin
			clk_en_q <= gate_en; // R01
			fault_q <= fault_d; // R02
		end
	end

endmodule : scgb_unit_gate

/* File: design/scgb_top.sv */
`timescale 1ns/1ps
`include "scgb_regs.svh"

// Summary of operation
// (R01) set bit clocks unit, clear bit stops it
// (R02) access to gated unit gives bus fault
// (R03) gating bits reset to zero unless noted
// (R04) run, sleep, deep-sleep registers per mode
// (R05) low-power registers apply only with auto gating
// (R06) bit 6 hibernate enable, resets to one
// (R07) bit 3 watchdog enable, resets to zero
// (R08) other bits read-only, read as zero
// (R09) sleep register at 0x110, reset 0x40
// (R10) auto gating off keeps run settings
module scgb_top
	import scgb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SCGB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire scgb_mode_t power_mode,
	input wire logic hib_access,
	input wire logic wdt_access,
	output logic hibernate_clock_enable,
	output logic watchdog_clock_enable,
	output logic hib_fault,
	output logic wdt_fault,
	output logic irq
);

	scgb_apb_st_t apb_st_q;
	scgb_apb_st_t apb_st_d;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	logic [`SCGB_IRQ_W-1:0] ist_q;
	logic [`SCGB_IRQ_W-1:0] ist_d;
	logic [`SCGB_IRQ_W-1:0] imsk_q;
	logic [`SCGB_IRQ_W-1:0] imsk_d;
	logic [`SCGB_IRQ_W-1:0] ist_set;
	logic [`SCGB_IRQ_W-1:0] ist_clr;
	logic [31:0] run_q;
	logic [31:0] sleep_q;
	logic [31:0] deep_q;
	logic [31:0] cfg_q;
	logic [31:0] state_word;
	logic [31:0] eff_gate;
	logic [31:0] rd_mux;
	logic auto_clock_gating_enable;
	logic apb_req;
	logic apb_done;
	logic wr_done;
	logic hit_run;
	logic hit_sleep;
	logic hit_deep;
	logic hit_cfg;
	logic hit_ist;
	logic hit_imsk;
	logic hit_state;
	logic hit_any;

	// bus decode; writes land only on the completing edge
	assign apb_req = psel & penable;
	assign apb_done = apb_req & pready_q & (apb_st_q == SCGB_APB_ACK);
	assign wr_done = apb_done & pwrite & ~pslverr_q;
	assign hit_run = (paddr == `SCGB_RUN_OFS);
	assign hit_sleep = (paddr == `SCGB_SLEEP_OFS); // R09
	assign hit_deep = (paddr == `SCGB_DEEP_OFS);
	assign hit_cfg = (paddr == `SCGB_CFG_OFS);
	assign hit_ist = (paddr == `SCGB_IST_OFS);
	assign hit_imsk = (paddr == `SCGB_IMSK_OFS);
	assign hit_state = (paddr == `SCGB_STATE_OFS);
	assign hit_any = hit_run | hit_sleep | hit_deep | hit_cfg | hit_ist | hit_imsk | hit_state;

	scgb_gate_reg #(
		.RST_VAL(`SCGB_GATE_RST),
		.WR_MASK(`SCGB_GATE_WMASK)
	) u_run (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_done & hit_run),
		.wdata(pwdata),
		.value_q(run_q)
	);

	scgb_gate_reg #(
		.RST_VAL(`SCGB_GATE_RST),
		.WR_MASK(`SCGB_GATE_WMASK)
	) u_sleep (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_done & hit_sleep),
		.wdata(pwdata),
		.value_q(sleep_q)
	);

	scgb_gate_reg #(
		.RST_VAL(`SCGB_GATE_RST),
		.WR_MASK(`SCGB_GATE_WMASK)
	) u_deep (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_done & hit_deep),
		.wdata(pwdata),
		.value_q(deep_q)
	);

	scgb_gate_reg #(
		.RST_VAL(`SCGB_CFG_RST),
		.WR_MASK(`SCGB_CFG_WMASK)
	) u_cfg (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_done & hit_cfg),
		.wdata(pwdata),
		.value_q(cfg_q)
	);

	assign auto_clock_gating_enable = cfg_q[`SCGB_ACG_BIT];

	// low-power words only count once auto gating is on
	always_comb
	begin
		case (power_mode)
			SCGB_MODE_RUN: eff_gate = run_q; // R04
			SCGB_MODE_SLEEP: eff_gate = auto_clock_gating_enable ? sleep_q : run_q; // R05 R10
			SCGB_MODE_DEEP: eff_gate = auto_clock_gating_enable ? deep_q : run_q; // R05 R10
			default: eff_gate = run_q;
		endcase
	end

	scgb_unit_gate u_hib (
		.pclk(pclk),
		.presetn(presetn),
		.gate_en(eff_gate[`SCGB_HIB_BIT]), // R06
		.access(hib_access),
		.clk_en_q(hibernate_clock_enable),
		.fault_q(hib_fault)
	);

	scgb_unit_gate u_wdt (
		.pclk(pclk),
		.presetn(presetn),
		.gate_en(eff_gate[`SCGB_WDT_BIT]), // R07
		.access(wdt_access),
		.clk_en_q(watchdog_clock_enable),
		.fault_q(wdt_fault)
	);

	// live view of what the units are really getting
	assign state_word = {22'h0, power_mode, 1'b0, hibernate_clock_enable, 2'h0,
		watchdog_clock_enable, 3'h0};

	// reserved bits already zero inside the stored words
	assign rd_mux = ({32{hit_run}} & run_q) | // R08
		({32{hit_sleep}} & sleep_q) |
		({32{hit_deep}} & deep_q) |
		({32{hit_cfg}} & cfg_q) |
		({32{hit_ist}} & {30'h0, ist_q}) |
		({32{hit_imsk}} & {30'h0, imsk_q}) |
		({32{hit_state}} & state_word);

	// set wins over a same-cycle write-one clear
	assign ist_set = {wdt_fault, hib_fault};
	assign ist_clr = (wr_done & hit_ist) ? pwdata[`SCGB_IRQ_W-1:0] : `SCGB_IRQ_RST;
	assign ist_d = (ist_q & ~ist_clr) | ist_set;
	assign imsk_d = (wr_done & hit_imsk) ? pwdata[`SCGB_IRQ_W-1:0] : imsk_q;

	always_comb
	begin
		case (apb_st_q)
			SCGB_APB_IDLE: apb_st_d = apb_req ? SCGB_APB_ACK : SCGB_APB_IDLE;
			SCGB_APB_ACK: apb_st_d = SCGB_APB_IDLE;
			default: apb_st_d = SCGB_APB_IDLE;
		endcase
	end

	// one wait state buys registered read data and error
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			apb_st_q <= SCGB_APB_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			apb_st_q <= apb_st_d;
			pready_q <= (apb_st_q == SCGB_APB_IDLE) & apb_req;
			pslverr_q <= (apb_st_q == SCGB_APB_IDLE) & apb_req & ~hit_any;
			prdata_q <= ((apb_st_q == SCGB_APB_IDLE) & apb_req & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ist_q <= `SCGB_IRQ_RST;
			imsk_q <= `SCGB_IRQ_RST;
			irq_q <= 1'b0;
		end
		else
		begin
			ist_q <= ist_d;
			imsk_q <= imsk_d;
			irq_q <= |(ist_d & imsk_d);
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;

	chk_sleep_reset: assert property (@(posedge pclk) disable iff (!presetn) // R09
		$rose(presetn) |-> (sleep_q == `SCGB_GATE_RST))
		else $error("sleep word not at reset value");

	chk_wdt_reset_off: assert property (@(posedge pclk) disable iff (!presetn) // R03
		$rose(presetn) |-> (!deep_q[`SCGB_WDT_BIT] && !run_q[`SCGB_WDT_BIT] && !watchdog_clock_enable))
		else $error("watchdog enabled out of reset");

	chk_gated_fault: assert property (@(posedge pclk) disable iff (!presetn) // R02
		(wdt_access && !watchdog_clock_enable) |=> wdt_fault)
		else $error("gated watchdog access gave no fault");

	chk_open_no_fault: assert property (@(posedge pclk) disable iff (!presetn) // R01
		(hib_access && hibernate_clock_enable) |=> !hib_fault)
		else $error("fault on clocked hibernate unit");

	chk_sleep_select: assert property (@(posedge pclk) disable iff (!presetn) // R04
		(auto_clock_gating_enable && power_mode == SCGB_MODE_SLEEP) |=> (hibernate_clock_enable == $past(sleep_q[`SCGB_HIB_BIT])))
		else $error("sleep word not applied in sleep");

	chk_deep_select: assert property (@(posedge pclk) disable iff (!presetn) // R05
		(auto_clock_gating_enable && power_mode == SCGB_MODE_DEEP) |=> (watchdog_clock_enable == $past(deep_q[`SCGB_WDT_BIT])))
		else $error("deep-sleep word not applied");

	// sampled presetn keeps the release-edge attempt vacuous; enables load one edge later
	chk_run_fallback: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(presetn && !auto_clock_gating_enable) |=> (watchdog_clock_enable == $past(run_q[`SCGB_WDT_BIT])
			&& hibernate_clock_enable == $past(run_q[`SCGB_HIB_BIT])))
		else $error("run word not kept without auto gating");

	chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn) // R08
		(apb_done && !pwrite && (hit_run || hit_sleep || hit_deep)) |-> ((prdata & ~`SCGB_GATE_WMASK) == 32'h0))
		else $error("reserved gating bits read nonzero");

	chk_hib_write: assert property (@(posedge pclk) disable iff (!presetn) // R06
		(wr_done && hit_sleep) |=> (sleep_q[`SCGB_HIB_BIT] == $past(pwdata[`SCGB_HIB_BIT])))
		else $error("hibernate bit did not take write");

	chk_wdt_write: assert property (@(posedge pclk) disable iff (!presetn) // R07
		(wr_done && hit_deep) |=> ##1 (watchdog_clock_enable == $past(pwdata[`SCGB_WDT_BIT], 2)
			|| $past(power_mode) != SCGB_MODE_DEEP || !$past(auto_clock_gating_enable)))
		else $error("watchdog bit write not applied");

	chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		(hib_fault && imsk_d[`SCGB_IRQ_HIB_BIT]) |=> irq)
		else $error("masked-in fault raised no interrupt");

	chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(penable) && psel && apb_st_q == SCGB_APB_IDLE) |-> !pready ##1 pready)
		else $error("bus answer not after one wait state");

	chk_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> (prdata == 32'h0000_0000))
		else $error("read data not zero outside answer");

	chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_done && !hit_any) |-> pslverr)
		else $error("unmapped access gave no error");

	chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_done && hit_any) |-> !pslverr)
		else $error("mapped access gave an error");

	chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready stood more than one cycle");

	chk_unmapped_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_done && pwrite && !hit_any) |=> ($stable(run_q) && $stable(sleep_q) && $stable(deep_q)
			&& $stable(cfg_q) && $stable(imsk_q)))
		else $error("unmapped write changed a register");

	chk_hib_gated_fault: assert property (@(posedge pclk) disable iff (!presetn) // R02
		(hib_access && !hibernate_clock_enable) |=> hib_fault)
		else $error("gated hibernate access gave no fault");

	chk_wdt_open_no_fault: assert property (@(posedge pclk) disable iff (!presetn) // R01
		(wdt_access && watchdog_clock_enable) |=> !wdt_fault)
		else $error("fault on clocked watchdog unit");

	chk_fault_cause: assert property (@(posedge pclk) disable iff (!presetn) // R02
		hib_fault |-> ($past(hib_access) && !$past(hibernate_clock_enable)))
		else $error("hibernate fault without gated access");

	chk_hib_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		hib_fault |=> ist_q[`SCGB_IRQ_HIB_BIT])
		else $error("hibernate fault not latched in status");

	chk_wdt_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		wdt_fault |=> ist_q[`SCGB_IRQ_WDT_BIT])
		else $error("watchdog fault not latched in status");

	chk_ist_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_done && hit_ist && pwdata[`SCGB_IRQ_HIB_BIT] && !hib_fault) |=> !ist_q[`SCGB_IRQ_HIB_BIT])
		else $error("write-one did not clear status");

	chk_irq_match: assert property (@(posedge pclk) disable iff (!presetn)
		(irq == (|(ist_q & imsk_q))))
		else $error("interrupt level differs from status and mask");

	chk_run_select: assert property (@(posedge pclk) disable iff (!presetn) // R04
		(presetn && power_mode == SCGB_MODE_RUN) |=> (hibernate_clock_enable == $past(run_q[`SCGB_HIB_BIT])
			&& watchdog_clock_enable == $past(run_q[`SCGB_WDT_BIT])))
		else $error("run word not applied in run");

	chk_sleep_wdt: assert property (@(posedge pclk) disable iff (!presetn) // R04
		(auto_clock_gating_enable && power_mode == SCGB_MODE_SLEEP) |=> (watchdog_clock_enable == $past(sleep_q[`SCGB_WDT_BIT])))
		else $error("sleep word watchdog bit not applied");

	chk_deep_hib: assert property (@(posedge pclk) disable iff (!presetn) // R05
		(auto_clock_gating_enable && power_mode == SCGB_MODE_DEEP) |=> (hibernate_clock_enable == $past(deep_q[`SCGB_HIB_BIT])))
		else $error("deep-sleep word hibernate bit not applied");

	chk_cfg_rsvd: assert property (@(posedge pclk) disable iff (!presetn) // R08
		(apb_done && !pwrite && hit_cfg) |-> ((prdata & ~`SCGB_CFG_WMASK) == 32'h0))
		else $error("reserved config bits read nonzero");

	chk_ro_write: assert property (@(posedge pclk) disable iff (!presetn) // R08
		(wr_done && hit_run) |=> ((run_q & ~`SCGB_GATE_WMASK) == 32'h0))
		else $error("read-only run bits took a write");

	chk_hib_reset_on: assert property (@(posedge pclk) disable iff (!presetn) // R06
		$rose(presetn) |=> hibernate_clock_enable)
		else $error("hibernate unit not clocked after reset");

	chk_deep_reset: assert property (@(posedge pclk) disable iff (!presetn) // R03
		$rose(presetn) |-> (deep_q == `SCGB_GATE_RST && run_q == `SCGB_GATE_RST))
		else $error("gating words not at reset value");

endmodule : scgb_top

/* File: test/tb_sleep_clock_gating_bank0.sv */
`timescale 1ns/1ps
`include "scgb_regs.svh"

module tb_sleep_clock_gating_bank0
	import scgb_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, hib_access, wdt_access;
	logic [`SCGB_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, hib_en, wdt_en, hib_fault, wdt_fault, irq;
	scgb_mode_t power_mode;
	int mismatches, checked, cycles, seed, mode, k;
	int mreg[6];
	logic [11:0] ofs[6];

	scgb_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_mode(power_mode), .hib_access(hib_access), .wdt_access(wdt_access),
		.hibernate_clock_enable(hib_en), .watchdog_clock_enable(wdt_en),
		.hib_fault(hib_fault), .wdt_fault(wdt_fault), .irq(irq));

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic end_of_test();
		$display("counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// master holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wreg(input int i, input logic [31:0] d);
		apb(1'b1, ofs[i], d);
		chk({31'h0, err}, 32'h0, "write error");
		if (i == 4)
			mreg[4] = mreg[4] & ~(d & 32'h3);
		else
			mreg[i] = d & ((i == 3) ? `SCGB_CFG_WMASK : (i == 5) ? 32'h3 : `SCGB_GATE_WMASK);
	endtask : wreg

	task automatic rchk(input int i);
		apb(1'b0, ofs[i], 32'h0);
		chk(rd, mreg[i], "readback");
		chk({31'h0, err}, 32'h0, "read error");
	endtask : rchk

	function automatic int eff();
		if (mreg[3][0] && mode == int'(SCGB_MODE_SLEEP))
			return mreg[1];
		if (mreg[3][0] && mode == int'(SCGB_MODE_DEEP))
			return mreg[2];
		return mreg[0];
	endfunction : eff

	task automatic chk_irq();
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, {31'h0, |(mreg[4] & mreg[5])}, "irq");
	endtask : chk_irq

	task automatic chk_gate();
		int e;
		e = eff();
		repeat (2) @(posedge pclk);
		chk({31'h0, hib_en}, {31'h0, e[6]}, "hib enable");
		chk({31'h0, wdt_en}, {31'h0, e[3]}, "wdt enable");
		apb(1'b0, `SCGB_STATE_OFS, 32'h0);
		chk(rd, {22'h0, 2'(mode), 1'b0, e[6], 2'h0, e[3], 3'h0}, "state word");
		hib_access <= 1'b1;
		wdt_access <= 1'b1;
		@(posedge pclk);
		hib_access <= 1'b0;
		wdt_access <= 1'b0;
		@(posedge pclk);
		chk({31'h0, hib_fault}, {31'h0, ~e[6]}, "hib fault");
		chk({31'h0, wdt_fault}, {31'h0, ~e[3]}, "wdt fault");
		mreg[4] = mreg[4] | {30'h0, ~e[3], ~e[6]};
		chk_irq();
	endtask : chk_gate

	task automatic do_reset();
		presetn <= 1'b0;
		power_mode <= SCGB_MODE_RUN;
		mode = 0;
		mreg = '{32'h40, 32'h40, 32'h40, 0, 0, 0};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rchk(i);
		chk_gate();
		$display("test reset done");
	endtask : do_reset

	initial
	begin
		seed = 56307;
		cycles = 0;
		mismatches = 0;
		checked = 0;
		{psel, penable, pwrite, hib_access, wdt_access, presetn} = 6'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		power_mode = SCGB_MODE_RUN;
		ofs = '{`SCGB_RUN_OFS, `SCGB_SLEEP_OFS, `SCGB_DEEP_OFS, `SCGB_CFG_OFS, `SCGB_IST_OFS, `SCGB_IMSK_OFS};
		do_reset();
		for (int i = 0; i < 3; i++)
		begin
			wreg(i, 32'hffff_ffff);
			rchk(i);
			wreg(i, 32'h0);
			rchk(i);
		end
		$display("test read-only bits done");
		apb(1'b1, 12'h114, 32'hffff_ffff);
		chk({31'h0, err}, 32'h1, "unmapped write error");
		apb(1'b0, 12'h114, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped read error");
		chk(rd, 32'h0, "unmapped read data");
		$display("test unmapped done");
		wreg(5, 32'h3);
		repeat (60)
		begin
			k = $unsigned($random(seed)) % 4;
			wreg(k, $random(seed));
			mode = $unsigned($random(seed)) % 4;
			power_mode <= scgb_mode_t'(2'(mode));
			rchk(k);
			chk_gate();
		end
		$display("test random gating done");
		wreg(3, 32'h0);
		wreg(0, 32'h0);
		chk_gate();
		rchk(4);
		wreg(4, 32'h1);
		rchk(4);
		chk_irq();
		wreg(5, 32'h0);
		chk_irq();
		wreg(4, 32'h3);
		rchk(4);
		$display("test interrupt done");
		do_reset();
		end_of_test();
	end
endmodule : tb_sleep_clock_gating_bank0
